// ### hw/vst_pkg.sv
// Shared constants, offsets and carrier types of the video sync timing block
package vst_pkg;
	// Register byte offsets on the register bus
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_TIMING0 = 8'h04;
	localparam logic [7:0] OFS_TIMING1 = 8'h08;
	localparam logic [7:0] OFS_STATUS  = 8'h0C;

	// Control register fields
	localparam int CTL_STD_LSB      = 0;
	localparam int CTL_REGSTD_BIT   = 5;
	localparam int CTL_PIXVALID_BIT = 6;

	// Timing mode register fields
	localparam int TM_MODE_LSB      = 0;
	localparam int TM_BLANK_DIS_BIT = 3;

	// Second timing register fields
	localparam int T1_HWIDTH_LSB = 0;
	localparam int T1_OFFSET_LSB = 8;

	// Status register fields
	localparam int ST_VCNT_LSB  = 0;
	localparam int ST_FRAME_LSB = 16;
	localparam int ST_FIELD_BIT = 24;
	localparam int ST_PAL_BIT   = 25;

	// Reset values, the all-on converter mask and the PAL standard code
	localparam logic [1:0] STD_SEL_RESET = 2'h0;
	localparam logic [2:0] TMODE_RESET   = 3'h0;
	localparam logic [7:0] HWIDTH_RESET  = 8'h40;
	localparam logic [7:0] OFFSET_RESET  = 8'h10;
	localparam logic [5:0] DAC_EN_RESET  = 6'h38;
	localparam logic [5:0] DAC_EN_ALL    = 6'h3F;
	localparam logic [1:0] STD_PAL_CODE  = 2'h1;

	// Timing mode codes
	localparam logic [2:0] MODE_SLAVE_EMB  = 3'h0;
	localparam logic [2:0] MODE_MASTER_EMB = 3'h1;
	localparam logic [2:0] MODE_SLAVE_HF   = 3'h2;
	localparam logic [2:0] MODE_MASTER_HF  = 3'h3;
	localparam logic [2:0] MODE_SLAVE_HV   = 3'h4;
	localparam logic [2:0] MODE_MASTER_HV  = 3'h5;
	localparam logic [2:0] MODE_SLAVE_HF3  = 3'h6;

	// Line and frame timing counts in clocks and lines
	localparam logic [10:0] LINE_CLKS_NTSC = 11'h6B4;
	localparam logic [10:0] LINE_CLKS_PAL  = 11'h6C0;
	localparam logic [10:0] ACTIVE_CLKS    = 11'h5A0;
	localparam logic [10:0] LINES_NTSC     = 11'h20D;
	localparam logic [10:0] LINES_PAL      = 11'h271;
	localparam logic [10:0] FIELD2_NTSC    = 11'h107;
	localparam logic [10:0] FIELD2_PAL     = 11'h139;
	localparam logic [10:0] VBI_NTSC       = 11'h015;
	localparam logic [10:0] VBI_PAL        = 11'h016;
	localparam logic [10:0] VS_LINES       = 11'h003;

	// Data stream values
	localparam int         PIX_WIDTH    = 8;
	localparam int         FIFO_DEPTH   = 4;
	localparam logic [7:0] BLACK_CHROMA = 8'h80;
	localparam logic [7:0] BLACK_LUMA   = 8'h10;
	localparam logic [7:0] CODE_FF      = 8'hFF;
	localparam logic [7:0] CODE_00      = 8'h00;
	localparam int         XY_F_BIT     = 6;
	localparam int         XY_V_BIT     = 5;
	localparam int         XY_H_BIT     = 4;

	// One bit per bidirectional sync pin
	typedef struct packed {
		logic hsync;
		logic vsync;
		logic blank;
	} vst_pins_type;

	// Embedded timing code parser states
	typedef enum logic [1:0] {
		PARSE_IDLE,
		PARSE_FF,
		PARSE_Z1,
		PARSE_Z2
	} vst_parse_type;
endpackage : vst_pkg

// ### hw/vst_fifo.sv
// Small pixel FIFO with valid and ready on both sides
`timescale 1ns/1ns
module vst_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wptr;
		logic [PW-1:0]               rptr;
		logic [CW-1:0]               count;
		logic                        rdy;
	} vst_fifo_state_type;

	vst_fifo_state_type q;
	vst_fifo_state_type d;
	logic               push;
	logic               pop;

	// Ready is a flop so the input pin carries no logic
	assign in_ready  = q.rdy;
	assign out_valid = (q.count != '0);
	assign out_data  = q.mem[q.rptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Pointer wrap assumes a power of two depth
	always_comb begin
		d = q;
		if (push) begin
			d.mem[q.wptr] = in_data;
			d.wptr        = q.wptr + PW'(1);
		end
		if (pop) begin
			d.rptr = q.rptr + PW'(1);
		end
		if (push && !pop) begin
			d.count = q.count + CW'(1);
		end else if (pop && !push) begin
			d.count = q.count - CW'(1);
		end
		d.rdy = (d.count != FULL);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q     <= '0;
			q.rdy <= 1'b1;
		end else begin
			q <= d;
		end
	end
endmodule : vst_fifo

// ### hw/vst_counter.sv
// Wrapping position counter with load, used for pixel and line position
`timescale 1ns/1ns
module vst_counter #(
	parameter int WIDTH = 11
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             advance,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] load_value,
	input  wire logic [WIDTH-1:0] last_value,
	output logic      [WIDTH-1:0] count,
	output logic                  at_last
);
	typedef struct packed {
		logic [WIDTH-1:0] cnt;
	} vst_cnt_state_type;

	vst_cnt_state_type q;
	vst_cnt_state_type d;

	assign count   = q.cnt;
	assign at_last = (q.cnt >= last_value);

	// A load from a sync edge beats the free running step
	always_comb begin
		d = q;
		if (load) begin
			d.cnt = load_value;
		end else if (advance) begin
			d.cnt = at_last ? '0 : q.cnt + WIDTH'(1);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule : vst_counter

// ### hw/vst_video_timing.sv
// Video timing front end: sync modes, reset sequence and register slave
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
// Notes on behaviour
// RULE1: Four master, four slave sync pin configurations
// RULE2: Second timing register sets widths and offsets
// RULE3: Reset restores every default setting
// RULE4: Standard follows select pin until overridden
// RULE5: Black data, suppressed timing until pixel valid
// RULE6: After reset converters A-C off, D-F on
// RULE7: Pixel valid passes data and enables timing
// RULE8: Register standard bit selects programmed standard
// RULE9: Mode 000 times from embedded codes
// RULE10: Board holds unused sync pins high
// RULE11: Mode 001 drives H, V, F flags
// RULE12: Mode 010 field toggle, hsync low frames
// RULE13: Mode 011 generates hsync and field
// RULE14: Disabled blank input means internal blanking
// RULE15: Mode 100 coincident falls mark odd field
// RULE16: Mode 101 generates same field encoding
// RULE17: Modes 11x field toggle, hsync high frames
// RULE18: Blank pin honoured only when enabled
// RULE19: Master drives sync pins, slave receives; slave mode 000 still drives the blank pin
module vst_video_timing (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic                 standard_select_pin,
	input  wire logic [7:0]           pix_in_data,
	input  wire logic                 pix_in_valid,
	output logic                      pix_in_ready,
	output logic      [7:0]           pix_out_data,
	output logic                      pix_out_valid,
	input  wire logic                 pix_out_ready,
	input  wire vst_pkg::vst_pins_type sync_in,
	output vst_pkg::vst_pins_type     sync_out,
	output vst_pkg::vst_pins_type     sync_oe,
	output logic      [5:0]           dac_enable,
	output logic                      std_pal
);
	typedef struct packed {
		logic [1:0]             std_sel;
		logic                   reg_std;
		logic                   pix_valid;
		logic [2:0]             tmode;
		logic                   blank_dis;
		logic [7:0]             hwidth;
		logic [7:0]             offset;
		logic [31:0]            prdata;
		logic                   pready;
		logic                   pslverr;
		vst_pkg::vst_parse_type pst;
		logic                   emb_h;
		logic                   emb_v;
		logic                   field;
		logic [7:0]             frames;
		vst_pkg::vst_pins_type  prev;
		logic [7:0]             out_data;
		logic                   out_valid;
		logic                   chroma_next;
		vst_pkg::vst_pins_type  pins_o;
		vst_pkg::vst_pins_type  pins_oe;
		logic [5:0]             dac_en;
		logic                   pal;
	} vst_state_type;

	vst_state_type q;
	vst_state_type d;
	logic [7:0]    f_data;
	logic          f_valid;
	logic          f_ready;
	logic          take;
	logic [10:0]   h_cnt;
	logic [10:0]   v_cnt;
	logic          h_last;
	logic          v_last;
	logic          h_load;
	logic          v_load;
	logic [10:0]   h_load_val;
	logic [10:0]   v_load_val;
	logic [10:0]   line_len;
	logic [10:0]   line_last;
	logic [10:0]   frame_last;
	logic [10:0]   f2;
	logic [10:0]   vbi;
	logic [10:0]   half;
	logic [10:0]   tog_pos;
	logic          hs_low;
	logic          vs_low;
	logic          vblank;
	logic          hblank;
	logic          blank_act;
	logic          hs_fall;
	logic          vs_fall;
	logic          fld_tog;
	logic          is_master;
	logic          slave_sync;
	logic          setup;
	logic          wr;

	// Pixels enter through the FIFO; the output register stalls it
	vst_fifo #(
		.WIDTH (vst_pkg::PIX_WIDTH),
		.DEPTH (vst_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_data   (pix_in_data),
		.in_valid  (pix_in_valid),
		.in_ready  (pix_in_ready),
		.out_data  (f_data),
		.out_valid (f_valid),
		.out_ready (f_ready)
	);

	assign f_ready = !q.out_valid || pix_out_ready;
	assign take    = f_valid && f_ready;

	// Pixel and line position counters
	vst_counter #(
		.WIDTH (11)
	) u_hcnt (
		.clk        (clk),
		.rst        (rst),
		.advance    (1'b1),
		.load       (h_load),
		.load_value (h_load_val),
		.last_value (line_last),
		.count      (h_cnt),
		.at_last    (h_last)
	);

	vst_counter #(
		.WIDTH (11)
	) u_vcnt (
		.clk        (clk),
		.rst        (rst),
		.advance    (h_last),
		.load       (v_load),
		.load_value (v_load_val),
		.last_value (frame_last),
		.count      (v_cnt),
		.at_last    (v_last)
	);

	// Standard dependent geometry
	always_comb begin
		line_len   = q.pal ? vst_pkg::LINE_CLKS_PAL : vst_pkg::LINE_CLKS_NTSC;
		line_last  = line_len - 11'h001;
		frame_last = (q.pal ? vst_pkg::LINES_PAL : vst_pkg::LINES_NTSC)
			- 11'h001;
		f2         = q.pal ? vst_pkg::FIELD2_PAL : vst_pkg::FIELD2_NTSC;
		vbi        = q.pal ? vst_pkg::VBI_PAL : vst_pkg::VBI_NTSC;
		half       = {1'b0, line_len[10:1]};
	end

	// Generated pulse shapes; hsync width and toggle spacing from the second register, vsync length fixed at VS_LINES
	always_comb begin
		tog_pos = 11'h000;
		if (q.tmode[2:1] == 2'b11) begin
			tog_pos = {3'b000, q.hwidth} + {3'b000, q.offset}; // RULE2 RULE17
		end
		hs_low = (h_cnt < {3'b000, q.hwidth}); // RULE2
		vs_low = (v_cnt < vst_pkg::VS_LINES)
			|| ((v_cnt == f2) && (h_cnt >= half))
			|| ((v_cnt > f2) && (v_cnt < f2 + vst_pkg::VS_LINES))
			|| ((v_cnt == f2 + vst_pkg::VS_LINES) && (h_cnt < half)); // RULE16
		vblank = (v_cnt < vbi) || ((v_cnt >= f2) && (v_cnt < f2 + vbi));
		hblank = (h_cnt >= vst_pkg::ACTIVE_CLKS);
	end

	// Slave edge detection on the synchronous sync inputs
	always_comb begin
		hs_fall    = q.prev.hsync && !sync_in.hsync;
		vs_fall    = q.prev.vsync && !sync_in.vsync;
		fld_tog    = q.prev.vsync != sync_in.vsync;
		// Before pixel valid the timing runs as master
		is_master  = !q.pix_valid || q.tmode[0];
		slave_sync = !is_master && (q.tmode != vst_pkg::MODE_SLAVE_EMB);
	end

	// Counter realignment from incoming sync in the slave options
	always_comb begin
		h_load     = 1'b0;
		v_load     = 1'b0;
		h_load_val = 11'h000;
		v_load_val = 11'h000;
		if (!is_master) begin
			unique case (q.tmode)
				vst_pkg::MODE_SLAVE_EMB: begin
					// End-of-active code realigns to blanking start
					if (take && q.pst == vst_pkg::PARSE_Z2
						&& f_data[vst_pkg::XY_H_BIT]) begin
						h_load     = 1'b1;
						h_load_val = vst_pkg::ACTIVE_CLKS; // RULE9
					end
					if (take && q.pst == vst_pkg::PARSE_Z2
						&& f_data[vst_pkg::XY_F_BIT] != q.field) begin
						v_load     = 1'b1;
						v_load_val = f_data[vst_pkg::XY_F_BIT] ? f2 : 11'h000; // RULE9
					end
				end
				vst_pkg::MODE_SLAVE_HF: begin
					h_load = hs_fall;
					v_load = fld_tog && !sync_in.hsync; // RULE12
				end
				vst_pkg::MODE_SLAVE_HV: begin
					h_load     = hs_fall;
					v_load     = vs_fall; // RULE15
					v_load_val = hs_fall ? 11'h000 : f2;
				end
				default: begin
					h_load = hs_fall;
					v_load = fld_tog && sync_in.hsync; // RULE17
				end
			endcase
		end
	end

	// Blank source: external pin only when enabled in a sync pin slave mode
	always_comb begin
		if (slave_sync && !q.blank_dis) begin
			blank_act = !sync_in.blank; // RULE18
		end else if (!is_master) begin
			blank_act = (q.tmode == vst_pkg::MODE_SLAVE_EMB)
				? (q.emb_h || q.emb_v) : (vblank || hblank); // RULE14
		end else begin
			blank_act = vblank || hblank; // RULE14
		end
	end

	assign setup = psel && !penable;
	assign wr    = psel && penable && pready && pwrite && !pslverr;

	// Next state of everything held in the block
	always_comb begin
		d      = q;
		d.prev = sync_in;
		// Register slave: decode in setup, answer in access phase
		d.pready  = setup;
		d.pslverr = 1'b0;
		d.prdata  = 32'h0000_0000;
		if (setup) begin
			unique case (paddr)
				vst_pkg::OFS_CONTROL: begin
					d.prdata[vst_pkg::CTL_STD_LSB +: 2]    = q.std_sel;
					d.prdata[vst_pkg::CTL_REGSTD_BIT]      = q.reg_std;
					d.prdata[vst_pkg::CTL_PIXVALID_BIT]    = q.pix_valid;
				end
				vst_pkg::OFS_TIMING0: begin
					d.prdata[vst_pkg::TM_MODE_LSB +: 3]    = q.tmode;
					d.prdata[vst_pkg::TM_BLANK_DIS_BIT]    = q.blank_dis;
				end
				vst_pkg::OFS_TIMING1: begin
					d.prdata[vst_pkg::T1_HWIDTH_LSB +: 8]  = q.hwidth;
					d.prdata[vst_pkg::T1_OFFSET_LSB +: 8]  = q.offset;
				end
				vst_pkg::OFS_STATUS: begin
					d.prdata[vst_pkg::ST_VCNT_LSB +: 11]   = v_cnt;
					d.prdata[vst_pkg::ST_FRAME_LSB +: 8]   = q.frames;
					d.prdata[vst_pkg::ST_FIELD_BIT]        = q.field;
					d.prdata[vst_pkg::ST_PAL_BIT]          = q.pal;
				end
				default: begin
					d.pslverr = 1'b1;
				end
			endcase
		end
		if (wr) begin
			unique case (paddr)
				vst_pkg::OFS_CONTROL: begin
					d.std_sel   = pwdata[vst_pkg::CTL_STD_LSB +: 2];
					d.reg_std   = pwdata[vst_pkg::CTL_REGSTD_BIT]; // RULE8
					d.pix_valid = pwdata[vst_pkg::CTL_PIXVALID_BIT]; // RULE7
				end
				vst_pkg::OFS_TIMING0: begin
					d.tmode     = pwdata[vst_pkg::TM_MODE_LSB +: 3];
					d.blank_dis = pwdata[vst_pkg::TM_BLANK_DIS_BIT];
				end
				vst_pkg::OFS_TIMING1: begin
					d.hwidth = pwdata[vst_pkg::T1_HWIDTH_LSB +: 8]; // RULE2
					d.offset = pwdata[vst_pkg::T1_OFFSET_LSB +: 8]; // RULE2
				end
				default: begin
					d.pst = q.pst;
				end
			endcase
		end

		// Pin level rules unless software picks the standard
		d.pal = q.reg_std ? (q.std_sel == vst_pkg::STD_PAL_CODE)
			: standard_select_pin; // RULE4 RULE8

		// Converters A-C stay off until real pixels flow
		d.dac_en = q.pix_valid ? vst_pkg::DAC_EN_ALL
			: vst_pkg::DAC_EN_RESET; // RULE6 RULE7

		// Embedded code parser: FF 00 00 then the flag byte
		if (take) begin
			unique case (q.pst)
				vst_pkg::PARSE_IDLE: begin
					if (f_data == vst_pkg::CODE_FF) begin
						d.pst = vst_pkg::PARSE_FF;
					end
				end
				vst_pkg::PARSE_FF: begin
					d.pst = (f_data == vst_pkg::CODE_00)
						? vst_pkg::PARSE_Z1 : vst_pkg::PARSE_IDLE;
				end
				vst_pkg::PARSE_Z1: begin
					d.pst = (f_data == vst_pkg::CODE_00)
						? vst_pkg::PARSE_Z2 : vst_pkg::PARSE_IDLE;
				end
				vst_pkg::PARSE_Z2: begin
					d.pst   = vst_pkg::PARSE_IDLE;
					d.emb_h = f_data[vst_pkg::XY_H_BIT]; // RULE9
					d.emb_v = f_data[vst_pkg::XY_V_BIT]; // RULE9
				end
			endcase
		end

		// Field tracking: generated in master, received in slave
		if (is_master) begin
			if (h_cnt == tog_pos && v_cnt == 11'h000) begin
				d.field = 1'b0; // RULE13 RULE17
			end else if (h_cnt == tog_pos && v_cnt == f2) begin
				d.field = 1'b1; // RULE13 RULE17
			end
		end else if (q.tmode == vst_pkg::MODE_SLAVE_EMB) begin
			if (take && q.pst == vst_pkg::PARSE_Z2) begin
				d.field = f_data[vst_pkg::XY_F_BIT]; // RULE9
			end
		end else if (q.tmode == vst_pkg::MODE_SLAVE_HV) begin
			if (vs_fall) begin
				d.field = !hs_fall; // RULE15
			end
		end else begin
			d.field = sync_in.vsync; // RULE12 RULE17
		end
		if (h_cnt == 11'h000 && v_cnt == 11'h000) begin
			d.frames = q.frames + 8'h01;
		end

		// Pixel path: black until valid, and on blanked positions
		if (take) begin
			d.out_valid   = 1'b1;
			d.chroma_next = !q.chroma_next;
			if (!q.pix_valid || blank_act) begin
				d.out_data = q.chroma_next ? vst_pkg::BLACK_CHROMA
					: vst_pkg::BLACK_LUMA; // RULE5 RULE14 RULE18
			end else begin
				d.out_data = f_data; // RULE7
			end
		end else if (pix_out_ready) begin
			d.out_valid = 1'b0;
		end

		// Sync pin drive per timing mode
		d.pins_o  = '1;
		d.pins_oe = '0;
		if (q.pix_valid) begin
			if (q.tmode[0]) begin
				d.pins_oe = '1; // RULE1 RULE19
				unique case (q.tmode)
					vst_pkg::MODE_MASTER_EMB: begin
						d.pins_o.hsync = hblank; // RULE11
						d.pins_o.blank = vblank; // RULE11
						d.pins_o.vsync = q.field; // RULE11
					end
					vst_pkg::MODE_MASTER_HV: begin
						d.pins_o.hsync = !hs_low; // RULE16
						d.pins_o.vsync = !vs_low; // RULE16
						d.pins_o.blank = !blank_act;
					end
					default: begin
						d.pins_o.hsync = !hs_low; // RULE13 RULE17
						d.pins_o.vsync = q.field; // RULE13 RULE17
						d.pins_o.blank = !blank_act;
					end
				endcase
			end else if (q.tmode == vst_pkg::MODE_SLAVE_EMB) begin
				// Board ties the other pins high; blank still driven
				d.pins_oe.blank = 1'b1; // RULE10
				d.pins_o.blank  = !blank_act;
			end
		end
	end

	// Asynchronous reset returns every setting to its default
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q         <= '0; // RULE3
			q.std_sel <= vst_pkg::STD_SEL_RESET;
			q.tmode   <= vst_pkg::TMODE_RESET;
			q.hwidth  <= vst_pkg::HWIDTH_RESET;
			q.offset  <= vst_pkg::OFFSET_RESET;
			q.pst     <= vst_pkg::PARSE_IDLE;
			q.prev    <= '1;
			q.pins_o  <= '1;
			q.dac_en  <= vst_pkg::DAC_EN_RESET; // RULE6
		end else begin
			q <= d;
		end
	end

	assign prdata        = q.prdata;
	assign pready        = q.pready;
	assign pslverr       = q.pslverr;
	assign pix_out_data  = q.out_data;
	assign pix_out_valid = q.out_valid;
	assign sync_out      = q.pins_o;
	assign sync_oe       = q.pins_oe;
	assign dac_enable    = q.dac_en;
	assign std_pal       = q.pal;

	// Checks on the timing behaviour
	AST_DAC_OFF: assert property (@(posedge clk) disable iff (rst) // RULE6
		!q.pix_valid |=> dac_enable == vst_pkg::DAC_EN_RESET)
		else $error("converters A-C not held off");
	AST_SUPPRESS: assert property (@(posedge clk) disable iff (rst) // RULE5
		!q.pix_valid |=> sync_oe == 3'b000)
		else $error("timing outputs driven before pixel valid");
	AST_BLACK: assert property (@(posedge clk) disable iff (rst) // RULE5
		(take && !q.pix_valid) |=> (pix_out_data == vst_pkg::BLACK_LUMA
			|| pix_out_data == vst_pkg::BLACK_CHROMA))
		else $error("non black pixel before pixel valid");
	AST_PIN_STD: assert property (@(posedge clk) disable iff (rst) // RULE4
		!q.reg_std ##1 !q.reg_std |-> std_pal == $past(standard_select_pin))
		else $error("standard does not follow select pin");
	AST_MASTER_DRV: assert property (@(posedge clk) disable iff (rst) // RULE19
		(q.pix_valid && q.tmode[0]) |=> sync_oe == 3'b111)
		else $error("master mode not driving sync pins");
	AST_SLAVE_IN: assert property (@(posedge clk) disable iff (rst) // RULE19
		(q.pix_valid && !q.tmode[0] && q.tmode != vst_pkg::MODE_SLAVE_EMB)
		|=> sync_oe == 3'b000)
		else $error("slave mode driving sync pins");
	AST_EMB_F: assert property (@(posedge clk) disable iff (rst) // RULE11
		(q.pix_valid && q.tmode == vst_pkg::MODE_MASTER_EMB)
		|=> sync_out.vsync == $past(q.field))
		else $error("field flag not on vertical sync pin");
	AST_ODD: assert property (@(posedge clk) disable iff (rst) // RULE15
		(q.pix_valid && q.tmode == vst_pkg::MODE_SLAVE_HV && hs_fall && vs_fall)
		|=> (!q.field && v_cnt == 11'h000))
		else $error("odd field start not recognised");
	AST_FRAME3: assert property (@(posedge clk) disable iff (rst) // RULE17
		(q.pix_valid && q.tmode == vst_pkg::MODE_SLAVE_HF3 && fld_tog
		&& sync_in.hsync) |=> v_cnt == 11'h000)
		else $error("mode 3 frame start missed");
	AST_BLANK_PIN: assert property (@(posedge clk) disable iff (rst) // RULE18
		(q.pix_valid && slave_sync && !q.blank_dis && take && !sync_in.blank)
		|=> (pix_out_data == vst_pkg::BLACK_LUMA
			|| pix_out_data == vst_pkg::BLACK_CHROMA))
		else $error("external blank ignored");
	AST_APB_WAIT: assert property (@(posedge clk) disable iff (rst)
		(psel && !penable) |=> pready)
		else $error("no answer in access phase");
	COV_VALID: cover property (@(posedge clk) disable iff (rst)
		$rose(q.pix_valid));
	COV_MASTER_HV: cover property (@(posedge clk) disable iff (rst)
		q.pix_valid && q.tmode == vst_pkg::MODE_MASTER_HV && !sync_out.vsync);
	COV_EMB: cover property (@(posedge clk) disable iff (rst)
		take && q.pst == vst_pkg::PARSE_Z2 && !is_master);
endmodule : vst_video_timing

// ### dv/vst_source_model.sv
// Upstream source model: sync pin drive and board pull-ups
`timescale 1ns/1ns
module vst_source_model (
	input  wire vst_pkg::vst_pins_type sync_out,
	input  wire vst_pkg::vst_pins_type sync_oe,
	input  wire vst_pkg::vst_pins_type src_drive,
	input  wire vst_pkg::vst_pins_type src_oe,
	output vst_pkg::vst_pins_type      sync_in
);
	logic [2:0] dev_o;
	logic [2:0] dev_e;
	logic [2:0] src_o;
	logic [2:0] src_e;

	// Device drive wins, then source; undriven pins float high
	assign dev_o = sync_out;
	assign dev_e = sync_oe;
	assign src_o = src_drive;
	assign src_e = src_oe;
	assign sync_in = (dev_e & dev_o) | (~dev_e & src_e & src_o)
		| (~dev_e & ~src_e);
endmodule : vst_source_model

// ### dv/test_vst_video_timing.sv
// Self-checking bench for the video sync timing front end
`timescale 1ns/1ns
module test_vst_video_timing;
	logic                  clk, rst, psel, penable, pwrite, pin_std;
	logic [7:0]            paddr, pix_in_data, pix_out_data;
	logic [31:0]           pwdata, prdata, rd;
	logic                  pready, pslverr, er, pix_in_valid;
	logic                  pix_in_ready, pix_out_valid, pix_out_ready;
	logic                  std_pal;
	logic [5:0]            dac_enable;
	vst_pkg::vst_pins_type sync_in, sync_out, sync_oe, src_drive, src_oe;
	int                    err_count, checked;

	vst_video_timing i_vst_video_timing (.clk(clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .standard_select_pin(pin_std),
		.pix_in_data(pix_in_data), .pix_in_valid(pix_in_valid),
		.pix_in_ready(pix_in_ready), .pix_out_data(pix_out_data),
		.pix_out_valid(pix_out_valid), .pix_out_ready(pix_out_ready),
		.sync_in(sync_in), .sync_out(sync_out), .sync_oe(sync_oe),
		.dac_enable(dac_enable), .std_pal(std_pal));
	// Source drives only what the slave scenarios ask for
	vst_source_model i_vst_source_model (.sync_out(sync_out),
		.sync_oe(sync_oe), .src_drive(src_drive), .src_oe(src_oe),
		.sync_in(sync_in));

	// Free-running 100 MHz clock
	always #5 clk = ~clk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; only the watchdog ends a hang
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic push(input logic [7:0] b);
		@(posedge clk);
		pix_in_data <= b;
		pix_in_valid <= 1'b1;
		do @(posedge clk); while (pix_in_ready !== 1'b1);
		pix_in_valid <= 1'b0;
	endtask : push

	// Sink stalls until the byte is seen, then takes it
	task automatic pull(input logic [7:0] exp);
		do @(posedge clk); while (pix_out_valid !== 1'b1);
		chk({24'h0, pix_out_data}, {24'h0, exp});
		pix_out_ready <= 1'b1;
		@(posedge clk);
		pix_out_ready <= 1'b0;
	endtask : pull

	task automatic fill_drain();
		int k;
		k = 0;
		@(posedge clk);
		pix_in_valid <= 1'b1;
		pix_in_data <= 8'h00;
		repeat (10) begin
			@(posedge clk);
			if (pix_in_ready === 1'b1) begin
				k++;
				pix_in_data <= 8'(k);
			end
		end
		pix_in_valid <= 1'b0;
		chk({31'h0, pix_in_ready}, 32'h0);
		chk(32'(k >= vst_pkg::FIFO_DEPTH), 32'h1);
		for (int i = 0; i < k; i++) pull(8'(i));
	endtask : fill_drain

	// Mode 100: lone vsync fall is even, coincident falls are odd
	task automatic slave_hv();
		apb(1'b1, vst_pkg::OFS_TIMING0, 32'h0000_0004);
		@(posedge clk);
		src_oe <= 3'b110;
		@(posedge clk);
		src_drive <= 3'b011;
		@(posedge clk);
		src_drive <= 3'b101;
		@(posedge clk);
		src_drive <= 3'b111;
		apb(1'b0, vst_pkg::OFS_STATUS, 32'h0);
		chk(rd & 32'h0100_07FF, (32'h1 << vst_pkg::ST_FIELD_BIT)
			| 32'(vst_pkg::FIELD2_NTSC));
		@(posedge clk);
		src_drive <= 3'b001;
		@(posedge clk);
		src_drive <= 3'b111;
		apb(1'b0, vst_pkg::OFS_STATUS, 32'h0);
		chk(rd & 32'h0100_07FF, 32'h0);
	endtask : slave_hv

	// Mode 010: a low blank pin blanks, a high one passes data
	task automatic blank_pin();
		apb(1'b1, vst_pkg::OFS_TIMING0, 32'h0000_0002);
		@(posedge clk);
		src_oe <= 3'b111;
		src_drive <= 3'b110;
		push(8'h5A);
		pull(vst_pkg::BLACK_LUMA);
		src_drive <= 3'b111;
		push(8'h5A);
		pull(8'h5A);
	endtask : blank_pin

	// Mode 000: a flag byte with H set blanks the bytes after it
	task automatic emb_code();
		apb(1'b1, vst_pkg::OFS_TIMING0, 32'h0000_0000);
		push(vst_pkg::CODE_FF);
		pull(vst_pkg::CODE_FF);
		push(vst_pkg::CODE_00);
		pull(vst_pkg::CODE_00);
		push(vst_pkg::CODE_00);
		pull(vst_pkg::CODE_00);
		push(8'h10);
		pull(8'h10);
		push(8'h5A);
		pull(vst_pkg::BLACK_LUMA);
	endtask : emb_code

	// Reset in mid-run brings the settings back to their defaults
	task automatic mid_reset();
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		chk({26'h0, dac_enable}, 32'(vst_pkg::DAC_EN_RESET));
		apb(1'b0, vst_pkg::OFS_CONTROL, 32'h0);
		chk(rd, 32'h0);
	endtask : mid_reset

	task automatic results();
		if (err_count == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : results

	// Watchdog against a hung handshake
	initial begin
		#200000;
		err_count++;
		results();
	end

	initial begin
		{clk, psel, penable, pwrite, pix_in_valid, pix_out_ready} = '0;
		{paddr, pwdata, pix_in_data} = '0;
		pin_std = 1'b1;
		src_drive = '1;
		src_oe = '0;
		rst = 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		chk({26'h0, dac_enable}, 32'h38);
		chk({29'h0, sync_oe}, 32'h0);
		chk({29'h0, sync_out}, 32'h7);
		repeat (2) @(posedge clk);
		chk({31'h0, std_pal}, 32'h1);
		apb(1'b0, vst_pkg::OFS_TIMING1, 32'h0);
		chk(rd, 32'h0000_1040);
		apb(1'b0, 8'h10, 32'h0);
		chk({31'h0, er}, 32'h1);
		apb(1'b1, vst_pkg::OFS_CONTROL, 32'h0000_0020);
		repeat (2) @(posedge clk);
		chk({31'h0, std_pal}, 32'h0);
		push(8'h11);
		push(8'h22);
		pull(vst_pkg::BLACK_LUMA);
		pull(vst_pkg::BLACK_CHROMA);
		apb(1'b1, vst_pkg::OFS_CONTROL, 32'h0000_0060);
		push(8'h5A);
		pull(8'h5A);
		fill_drain();
		for (int m = 0; m < 8; m++) begin
			apb(1'b1, vst_pkg::OFS_TIMING0, 32'(m));
			repeat (3) @(posedge clk);
			chk({31'h0, sync_oe.hsync}, 32'(m & 1));
		end
		slave_hv();
		blank_pin();
		emb_code();
		mid_reset();
		results();
	end
endmodule : test_vst_video_timing
